// ---- hw/uart_tx_defs.svh ----
`ifndef UART_TX_DEFS_SVH
`define UART_TX_DEFS_SVH

`define FRAME_W     12
`define LEN_W       4
`define K_W         8
`define DIV_W       9
`define DL_W        13
`define K_MIN       8'h02
`define DL_EXTRA    13'h0003
`define START_LVL   1'b0
`define IDLE_LVL    1'b1
`define LEN_BASE    4'h2
`define ONE_LEN     4'h1
`define DATA7_LEN   4'h7
`define DATA8_LEN   4'h8
`define DATA_W      8
`define PAR7_POS    8
`define PAR8_POS    9

`endif

// ---- hw/uart_tx_pkg.sv ----
package uart_tx_pkg;
  `include "uart_tx_defs.svh"

  typedef enum logic {sh_idle, sh_shift} sh_state_e;

  typedef struct packed {
    sh_state_e           st;
    logic [`FRAME_W-1:0] sh;
    logic [`LEN_W-1:0]   left;
    logic [`DIV_W-1:0]   div;
  } shf_s;

  typedef struct packed {
    logic [7:0]       hold;
    logic             full;
    logic             txd;
    logic             irq;
    logic             late;
    logic             busy;
    logic             waiting;
    logic [`DL_W-1:0] wait_cnt;
    logic [`DL_W-1:0] deadline;
  } ctl_s;
endpackage : uart_tx_pkg

// ---- hw/tx_link_if.sv ----
`timescale 1ns/1ps
`include "uart_tx_defs.svh"

interface tx_link_if;
  logic                load;
  logic [`FRAME_W-1:0] frame;
  logic [`LEN_W-1:0]   len;
  logic [`K_W-1:0]     k;
  logic                started;
  logic                line;
  logic                idle;

  modport ctl (output load, frame, len, k, input started, line, idle);
  modport shf (input load, frame, len, k, output started, line, idle);
endinterface : tx_link_if

// ---- hw/tx_shifter.sv ----
`timescale 1ns/1ps
`include "uart_tx_defs.svh"

module tx_shifter (
  input wire logic clk,
  input wire logic rst_b,
  tx_link_if.shf   lk
);
  import uart_tx_pkg::*;

  shf_s             s;
  shf_s             next_s;
  logic [`DIV_W-1:0] two_k;
  logic             tick;
  logic             last_tick;

  assign two_k     = {lk.k, 1'b0};
  // a smaller k mid-bit ends the bit at once instead of wrapping the divider
  assign tick      = (s.st == sh_shift) && (s.div >= two_k - `DIV_W'(1));
  assign last_tick = tick && (s.left == `ONE_LEN);
  // reload at the last bit edge keeps frames gapless
  assign lk.started = lk.load && ((s.st == sh_idle) || last_tick);
  assign lk.line    = (s.st == sh_idle) ? `IDLE_LVL : s.sh[0];
  assign lk.idle    = (s.st == sh_idle);

  always_comb
  begin
    next_s = s;
    case (s.st)
      sh_idle:
      begin
        if (lk.load)
        begin
          next_s.st   = sh_shift;
          next_s.sh   = lk.frame;
          next_s.left = lk.len;
          next_s.div  = '0;
        end
      end
      sh_shift:
      begin
        if (tick)
        begin
          next_s.div  = '0;
          next_s.sh   = {`IDLE_LVL, s.sh[`FRAME_W-1:1]};
          next_s.left = s.left - `ONE_LEN;
          if (last_tick)
          begin
            if (lk.load)
            begin
              next_s.sh   = lk.frame;
              next_s.left = lk.len;
            end
            else
            begin
              next_s.st = sh_idle;
            end
          end
        end
        else
        begin
          next_s.div = s.div + `DIV_W'(1);
        end
      end
      default: next_s.st = sh_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s.st   <= sh_idle;
      s.sh   <= '1;
      s.left <= '0;
      s.div  <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  idle_line_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s.st == sh_idle) |-> lk.line == `IDLE_LVL)
    else $error("line not idle while shifter idle");

  start_bit_held_a: assert property (@(posedge clk) disable iff (!rst_b)
    lk.started |=> (lk.line == `START_LVL)[*2])
    else $error("start bit not driven after frame start");

  frame_len_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    lk.started |=> (s.left == $past(lk.len)) && (s.st == sh_shift))
    else $error("frame length not loaded at start");
endmodule : tx_shifter

// ---- hw/uart_continuous_transmit.sv ----
`timescale 1ns/1ps
`include "uart_tx_defs.svh"

// Overview of operation
// - holding register separate from shift register
// - holding register writable once shifting starts
// - empty interrupt when holding register frees
// - k is baud divisor, 2 to 255
// - deadline counted in operating clock cycles
// - frame length counts start, data, parity, stops
module uart_continuous_transmit (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 wr_valid,
  input  wire logic [7:0]           wr_data,
  input  wire logic [`K_W-1:0]      baud_divisor_k,
  input  wire logic                 char_7bit,
  input  wire logic                 parity_en,
  input  wire logic                 parity_odd,
  input  wire logic                 stop_2bit,
  output logic                      txd,
  output logic                      buf_empty_irq,
  output logic                      refill_late,
  output logic                      buf_full,
  output logic                      tx_busy,
  output logic [`DL_W-1:0]          refill_deadline
);
  import uart_tx_pkg::*;

  tx_link_if lk ();

  ctl_s                s;
  ctl_s                next_s;
  logic [`K_W-1:0]     k_eff;
  logic [`LEN_W-1:0]   frame_len;
  logic [`FRAME_W-1:0] frame;
  logic [`DL_W-1:0]    two_k;
  logic [`DL_W-1:0]    dl_calc;
  logic                take;

  function automatic logic [`FRAME_W-1:0] build_frame(input logic [7:0] d, input logic seven,
                                                      input logic pen, input logic podd);
    logic [`FRAME_W-1:0] f;
    logic                par;
    f   = '1;
    f[0] = `START_LVL;
    par = podd;
    for (int i = 0; i < `DATA_W; i++)
    begin
      if (!(seven && i == `DATA_W - 1))
      begin
        f[1+i] = d[i];
        par    = par ^ d[i];
      end
    end
    if (pen)
    begin
      if (seven)
        f[`PAR7_POS] = par;
      else
        f[`PAR8_POS] = par;
    end
    return f;
  endfunction : build_frame

  function automatic logic [`LEN_W-1:0] frame_length(input logic seven, input logic pen, input logic two_stop);
    logic [`LEN_W-1:0] len;
    len = `LEN_BASE; // start and first stop
    if (seven)
      len = len + `DATA7_LEN;
    else
      len = len + `DATA8_LEN;
    if (pen)
      len = len + `ONE_LEN;
    if (two_stop)
      len = len + `ONE_LEN;
    return len;
  endfunction : frame_length

  assign k_eff = (baud_divisor_k < `K_MIN) ? `K_MIN : baud_divisor_k;
  assign frame_len = frame_length(char_7bit, parity_en, stop_2bit);
  assign frame = build_frame(s.hold, char_7bit, parity_en, parity_odd);
  assign two_k = {4'h0, k_eff, 1'b0};
  // deadline in cycles of the operating clock, which is clk here
  assign dl_calc = `DL_W'(frame_len * two_k) - (two_k + `DL_EXTRA);

  assign lk.load  = s.full;
  assign lk.frame = frame;
  assign lk.len   = frame_len;
  assign lk.k     = k_eff;

  // a write is taken while empty, or in the cycle the shifter takes the word
  assign take = wr_valid && (!s.full || lk.started);

  tx_shifter shifter (
    .clk   (clk),
    .rst_b (rst_b),
    .lk    (lk)
  );

  always_comb
  begin
    next_s          = s;
    next_s.txd      = lk.line;
    next_s.busy     = !lk.idle || s.full;
    next_s.deadline = dl_calc;
    next_s.irq      = lk.started;
    next_s.late     = 1'b0;
    if (lk.started)
    begin
      next_s.full     = 1'b0;
      next_s.waiting  = 1'b1;
      next_s.wait_cnt = '0;
    end
    else if (s.waiting && s.wait_cnt != '1)
    begin
      next_s.wait_cnt = s.wait_cnt + `DL_W'(1);
    end
    if (take)
    begin
      next_s.hold    = wr_data;
      next_s.full    = 1'b1;
      next_s.waiting = 1'b0;
      next_s.late    = s.waiting && !lk.started && (s.wait_cnt > s.deadline);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s.hold     <= '0;
      s.full     <= 1'b0;
      s.txd      <= `IDLE_LVL;
      s.irq      <= 1'b0;
      s.late     <= 1'b0;
      s.busy     <= 1'b0;
      s.waiting  <= 1'b0;
      s.wait_cnt <= '0;
      s.deadline <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign txd             = s.txd;
  assign buf_empty_irq   = s.irq;
  assign refill_late     = s.late;
  assign buf_full        = s.full;
  assign tx_busy         = s.busy;
  assign refill_deadline = s.deadline;

  irq_after_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    lk.started |=> buf_empty_irq ##1 !buf_empty_irq)
    else $error("empty interrupt not a single pulse after start");

  hold_freed_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lk.started && !wr_valid) |=> !buf_full)
    else $error("holding register not freed at shift start");

  write_taken_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_valid && (!buf_full || lk.started)) |=> buf_full && (s.hold == $past(wr_data)))
    else $error("write not stored in holding register");

  late_flagged_a: assert property (@(posedge clk) disable iff (!rst_b)
    (take && s.waiting && !lk.started && s.wait_cnt > s.deadline) |=> refill_late)
    else $error("late refill not flagged");

  k_clamped_a: assert property (@(posedge clk) disable iff (!rst_b)
    (k_eff >= `K_MIN) && ((baud_divisor_k < `K_MIN) || (k_eff == baud_divisor_k)))
    else $error("baud divisor outside valid range");

  late_one_cycle_a: assert property (@(posedge clk) disable iff (!rst_b)
    refill_late |=> !refill_late)
    else $error("late flag longer than one cycle");

  late_after_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    refill_late |-> $past(wr_valid) && $past(s.waiting))
    else $error("late flag without a refill write");

  no_late_in_time_a: assert property (@(posedge clk) disable iff (!rst_b)
    (take && (s.wait_cnt <= s.deadline)) |=> !refill_late)
    else $error("timely refill flagged late");

  write_ends_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    take |=> !s.waiting)
    else $error("wait count still running after refill");

  refused_hold_kept_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_valid && buf_full && !lk.started) |=> $stable(s.hold))
    else $error("refused write changed holding register");

  full_until_taken_a: assert property (@(posedge clk) disable iff (!rst_b)
    (buf_full && !lk.started) |=> buf_full)
    else $error("holding register lost before shift start");

  busy_while_full_a: assert property (@(posedge clk) disable iff (!rst_b)
    buf_full |=> tx_busy)
    else $error("busy low while a word is pending");

  irq_from_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    buf_empty_irq |-> $past(lk.started))
    else $error("empty interrupt without shift start");

  wait_zero_at_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
    buf_empty_irq |-> (s.wait_cnt == '0))
    else $error("wait count not cleared at empty interrupt");

  wait_count_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s.waiting && !lk.started && !take && (s.wait_cnt != '1)) |=> (s.wait_cnt == $past(s.wait_cnt) + `DL_W'(1)))
    else $error("wait count not one step per clock");

  txd_from_line_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> (txd == $past(lk.line)))
    else $error("serial output not the registered line");

  idle_when_empty_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!tx_busy && !buf_full) |-> (txd == `IDLE_LVL))
    else $error("line not idle with nothing to send");

  no_spurious_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!buf_full && lk.idle) |=> !buf_empty_irq)
    else $error("frame started with empty holding register");
endmodule : uart_continuous_transmit

// ---- tb/serial_rx_model.sv ----
`timescale 1ns/1ps

module serial_rx_model (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic [7:0] k,
  input  wire logic       char_7bit,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  input  wire logic       stop_2bit,
  output logic      [7:0] rx_data,
  output logic            rx_err,
  output int              rx_count
);
  logic [7:0] d;
  logic       p;
  initial
  begin
    rx_data  = 8'h00;
    rx_err   = 1'b0;
    rx_count = 0;
  end
  // start edge, then sample mid-bit every 2k cycles
  always
  begin
    @(negedge txd);
    repeat (k) @(posedge clk);
    if (txd !== 1'b0) rx_err = 1'b1;
    d = 8'h00;
    p = parity_odd;
    for (int i = 0; i < (char_7bit ? 7 : 8); i++)
    begin
      repeat (2 * k) @(posedge clk);
      d[i] = txd;
      p    = p ^ txd;
    end
    if (parity_en)
    begin
      repeat (2 * k) @(posedge clk);
      if (txd !== p) rx_err = 1'b1;
    end
    repeat (stop_2bit ? 2 : 1)
    begin
      repeat (2 * k) @(posedge clk);
      if (txd !== 1'b1) rx_err = 1'b1;
    end
    rx_data  = d;
    rx_count = rx_count + 1;
  end
endmodule : serial_rx_model

// ---- tb/uart_continuous_transmit_tb_top.sv ----
`timescale 1ns/1ps
`include "uart_tx_defs.svh"

module uart_continuous_transmit_tb_top;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                wr_valid = 1'b0;
  logic [7:0]          wr_data = 8'h00;
  logic [`K_W-1:0]     k = 8'h02;
  logic                c7 = 1'b0;
  logic                pe = 1'b0;
  logic                po = 1'b0;
  logic                s2 = 1'b0;
  logic                txd, irq, late, full, busy;
  logic [`DL_W-1:0]    dl;
  logic [7:0]          rx_data;
  logic                rx_err;
  int                  rx_count, n_fail, checks_done, n, rxn;

  always #5 clk = ~clk;

  uart_continuous_transmit uart_continuous_transmit_i (.clk(clk), .rst_b(rst_b), .wr_valid(wr_valid),
    .wr_data(wr_data), .baud_divisor_k(k), .char_7bit(c7), .parity_en(pe), .parity_odd(po),
    .stop_2bit(s2), .txd(txd), .buf_empty_irq(irq), .refill_late(late), .buf_full(full),
    .tx_busy(busy), .refill_deadline(dl));
  serial_rx_model serial_rx_model_i (.clk(clk), .txd(txd), .k((k < 8'h02) ? 8'h02 : k), .char_7bit(c7),
    .parity_en(pe), .parity_odd(po), .stop_2bit(s2), .rx_data(rx_data), .rx_err(rx_err), .rx_count(rx_count));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask : chk

  task automatic cfg(input logic [7:0] kk, input logic a, input logic b, input logic c, input logic e);
    @(posedge clk);
    #1 {k, c7, pe, po, s2} = {kk, a, b, c, e};
    repeat (3) @(posedge clk);
    #1;
  endtask : cfg

  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    #1 {wr_valid, wr_data} = {1'b1, d};
    @(posedge clk);
    #1 wr_valid = 1'b0;
  endtask : wr

  task automatic wait_irq();
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (irq !== 1'b1 && n < 5000);
  endtask : wait_irq

  task automatic rx_done(input logic [7:0] d);
    rxn++;
    for (int i = 0; i < 5000 && rx_count < rxn; i++) @(posedge clk);
    #1;
    chk("rx_data", 16'(rx_data), 16'(d));
    chk("rx_err", 16'(rx_err), 16'h0000);
  endtask : rx_done

  task automatic s_single();
    cfg(8'h02, 0, 0, 0, 0);
    chk("deadline 8n1", 16'(dl), 16'h0021);
    wr(8'ha5);
    chk("full", 16'(full), 16'h0001);
    wait_irq();
    chk("irq delay", 16'(n), 16'h0001);
    chk("busy", 16'(busy), 16'h0001);
    rx_done(8'ha5);
    repeat (20) @(posedge clk);
    chk("idle line", 16'({txd, busy, full}), 16'h0004);
    wr(8'h5a);
    rx_done(8'h5a);
  endtask : s_single

  task automatic s_gapless();
    cfg(8'h02, 0, 1, 0, 0);
    chk("deadline 8e1", 16'(dl), 16'h0025);
    wr(8'h3c);
    wait_irq();
    wr(8'hc3);
    wait_irq();
    chk("frame spacing", 16'(n + 2), 16'h002c);
    rx_done(8'h3c);
    rx_done(8'hc3);
  endtask : s_gapless

  task automatic s_deadline();
    wr(8'h11);
    wait_irq();
    repeat (36) @(posedge clk);
    wr(8'h22);
    chk("late at 37", 16'(late), 16'h0000);
    wr(8'h44);
    chk("refused write", 16'({full, late}), 16'h0002);
    wait_irq();
    repeat (37) @(posedge clk);
    wr(8'h33);
    chk("late at 38", 16'(late), 16'h0001);
    rx_done(8'h11);
    rx_done(8'h22);
    rx_done(8'h33);
  endtask : s_deadline

  task automatic s_modes();
    cfg(8'h03, 1, 1, 1, 1);
    chk("deadline 7o2", 16'(dl), 16'h0039);
    wr(8'hff);
    rx_done(8'h7f);
    cfg(8'h01, 0, 0, 0, 0);
    chk("deadline k clamp", 16'(dl), 16'h0021);
    cfg(8'hff, 1, 0, 0, 0);
    chk("deadline k max", 16'(dl), 16'h0fed);
  endtask : s_modes

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #500000 n_fail++;
    tally_and_finish();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("reset outputs", 16'({txd, irq, late, full, busy}), 16'h0010);
    s_single();
    s_gapless();
    s_deadline();
    s_modes();
    tally_and_finish();
  end
endmodule : uart_continuous_transmit_tb_top
